// ===== logic/dso_stop_option.sv
// Stop-reaction option decoding, quick-stop ramp and velocity unit scaling
`timescale 1ns/1ps
`default_nettype none

module dso_stop_option import dso_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Object access port
  input wire logic od_wr,
  input wire logic od_rd,
  input wire logic [15:0] od_index,
  input wire logic [7:0] od_subindex,
  input wire logic [31:0] od_wdata,
  output logic [31:0] od_rdata,
  output logic od_ack,
  output logic od_err,
  // Power state machine events
  input wire logic psm_enter_quick_stop,
  input wire logic psm_enabled_to_ready,
  input wire logic psm_enabled_to_switched_on,
  input wire logic psm_resume_operation,
  input wire logic motor_standstill,
  // Stop reaction outputs
  output dso_brake_e brake_sel,
  output logic drive_blocked,
  output logic hold_energized,
  output logic goto_valid,
  output dso_goto_e goto_state,
  // Velocity scaling
  input wire logic signed [31:0] speed_user,
  output logic signed [31:0] speed_rpm,
  output logic signed [31:0] qs_decel_rpm
);

  typedef enum logic [1:0] {DSO_ST_IDLE, DSO_ST_BRAKE, DSO_ST_HOLD} dso_state_e;

  // Object storage
  logic [31:0] spd_step_reg, spd_step_next;
  logic [15:0] time_step_reg, time_step_next;
  logic signed [31:0] num_reg, num_next;
  logic signed [31:0] den_reg, den_next;
  logic [15:0] qs_code_reg, qs_code_next;
  logic [15:0] sd_code_reg, sd_code_next;
  logic [15:0] dis_code_reg, dis_code_next;
  logic [31:0] rdata_reg, rdata_next;
  logic ack_reg, ack_next, err_reg, err_next;
  logic hit, bad;

  // Object decode, writes and reads; a refused write leaves storage untouched
  always_comb begin
    spd_step_next = spd_step_reg;
    time_step_next = time_step_reg;
    num_next = num_reg;
    den_next = den_reg;
    qs_code_next = qs_code_reg;
    sd_code_next = sd_code_reg;
    dis_code_next = dis_code_reg;
    rdata_next = rdata_reg;
    hit = 1'b1;
    bad = 1'b0;
    unique case (od_index)
      DSO_IDX_QS_RAMP, DSO_IDX_VEL_SCALE: begin
        if (od_subindex == DSO_SUB_COUNT) begin
          rdata_next = DSO_ENTRY_COUNT;
          bad = od_wr;
        end else if (od_subindex == DSO_SUB_FIRST) begin
          rdata_next = (od_index == DSO_IDX_QS_RAMP) ? spd_step_reg : num_reg;
          if (od_wr && od_index == DSO_IDX_QS_RAMP) spd_step_next = od_wdata;
          if (od_wr && od_index == DSO_IDX_VEL_SCALE) num_next = od_wdata;
        end else if (od_subindex == DSO_SUB_SECOND) begin
          rdata_next = (od_index == DSO_IDX_QS_RAMP) ? {16'h0000, time_step_reg} : den_reg;
          // Zero divisors would break the ramp and scaling divides
          bad = od_wr && ((od_index == DSO_IDX_QS_RAMP) ? (od_wdata[15:0] == 16'h0000) : (od_wdata == 32'h0000_0000));
          if (od_wr && !bad && od_index == DSO_IDX_QS_RAMP) time_step_next = od_wdata[15:0];
          if (od_wr && !bad && od_index == DSO_IDX_VEL_SCALE) den_next = od_wdata;
        end else begin
          hit = 1'b0;
        end
      end
      DSO_IDX_QS_CODE: begin
        rdata_next = {{16{qs_code_reg[15]}}, qs_code_reg};
        bad = od_wr && !(od_wdata[15:0] inside {DSO_CODE_0, DSO_CODE_1, DSO_CODE_2, DSO_CODE_5, DSO_CODE_6});
        if (od_wr && !bad) qs_code_next = od_wdata[15:0];
        hit = (od_subindex == DSO_SUB_COUNT);
      end
      DSO_IDX_SD_CODE: begin
        rdata_next = {{16{sd_code_reg[15]}}, sd_code_reg};
        bad = od_wr && !(od_wdata[15:0] inside {DSO_CODE_0, DSO_CODE_1});
        if (od_wr && !bad) sd_code_next = od_wdata[15:0];
        hit = (od_subindex == DSO_SUB_COUNT);
      end
      DSO_IDX_DIS_CODE: begin
        rdata_next = {{16{dis_code_reg[15]}}, dis_code_reg};
        bad = od_wr && !(od_wdata[15:0] inside {DSO_CODE_0, DSO_CODE_1});
        if (od_wr && !bad) dis_code_next = od_wdata[15:0];
        hit = (od_subindex == DSO_SUB_COUNT);
      end
      default: hit = 1'b0;
    endcase
    // Unknown object: nothing stored, read data zero
    if (!hit || !(od_wr || od_rd)) begin
      spd_step_next = spd_step_reg;
      time_step_next = time_step_reg;
      num_next = num_reg;
      den_next = den_reg;
      qs_code_next = qs_code_reg;
      sd_code_next = sd_code_reg;
      dis_code_next = dis_code_reg;
    end
    if (!hit && (od_wr || od_rd)) rdata_next = 32'h0000_0000;
    if (!od_rd) rdata_next = rdata_reg;
    ack_next = od_wr || od_rd;
    err_next = (od_wr || od_rd) && (!hit || bad);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      spd_step_reg <= DSO_RST_SPEED_STEP;
      time_step_reg <= DSO_RST_TIME_STEP;
      num_reg <= DSO_RST_SCALE;
      den_reg <= DSO_RST_SCALE;
      qs_code_reg <= DSO_RST_QS_CODE;
      sd_code_reg <= DSO_RST_SD_CODE;
      dis_code_reg <= DSO_RST_DIS_CODE;
      rdata_reg <= 32'h0000_0000;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      spd_step_reg <= spd_step_next;
      time_step_reg <= time_step_next;
      num_reg <= num_next;
      den_reg <= den_next;
      qs_code_reg <= qs_code_next;
      sd_code_reg <= sd_code_next;
      dis_code_reg <= dis_code_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
      err_reg <= err_next;
    end
  end

  assign od_rdata = rdata_reg;
  assign od_ack = ack_reg;
  assign od_err = err_reg;

  // Unit scaling; 64-bit products avoid overflow before the divide
  logic signed [31:0] speed_rpm_reg, speed_rpm_next, decel_reg, decel_next;
  logic signed [63:0] spd_prod, dec_prod, dec_div;

  always_comb begin
    spd_prod = 64'(speed_user) * 64'(num_reg);
    speed_rpm_next = 32'(spd_prod / 64'(den_reg));
    dec_prod = $signed({32'h0000_0000, spd_step_reg}) * 64'(num_reg);
    dec_div = 64'(den_reg) * $signed({48'h0000_0000_0000, time_step_reg});
    decel_next = 32'(dec_prod / dec_div);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      speed_rpm_reg <= 32'sh0000_0000;
      decel_reg <= 32'sh0000_0000;
    end else begin
      speed_rpm_reg <= speed_rpm_next;
      decel_reg <= decel_next;
    end
  end

  assign speed_rpm = speed_rpm_reg;
  assign qs_decel_rpm = decel_reg;

  // Stop reaction sequencer
  dso_state_e state_reg, state_next;
  dso_brake_e brake_reg, brake_next;
  dso_goto_e target_reg, target_next;
  logic hold_after_reg, hold_after_next, blocked_reg, blocked_next, goto_reg, goto_next;

  always_comb begin
    state_next = state_reg;
    brake_next = brake_reg;
    target_next = target_reg;
    hold_after_next = hold_after_reg;
    blocked_next = blocked_reg;
    goto_next = 1'b0;
    if (psm_enter_quick_stop) begin
      state_next = DSO_ST_BRAKE;
      blocked_next = 1'b0;
      target_next = DSO_GO_SWITCH_ON_DISABLED;
      hold_after_next = 1'b0;
      unique case (qs_code_reg)
        DSO_CODE_0: brake_next = DSO_BRK_IMMEDIATE;
        DSO_CODE_1: brake_next = DSO_BRK_SLOW;
        DSO_CODE_5: begin
          brake_next = DSO_BRK_SLOW;
          hold_after_next = 1'b1;
        end
        DSO_CODE_6: begin
          brake_next = DSO_BRK_QUICK;
          hold_after_next = 1'b1;
        end
        default: brake_next = DSO_BRK_QUICK;
      endcase
    end else if (psm_enabled_to_ready || psm_enabled_to_switched_on) begin
      target_next = psm_enabled_to_ready ? DSO_GO_READY : DSO_GO_SWITCHED_ON;
      hold_after_next = 1'b0;
      if ((psm_enabled_to_ready ? sd_code_reg : dis_code_reg) == DSO_CODE_0) begin
        // Blocking needs no ramp; transition proceeds at once
        blocked_next = 1'b1;
        brake_next = DSO_BRK_NONE;
        goto_next = 1'b1;
        state_next = DSO_ST_IDLE;
      end else begin
        blocked_next = 1'b0;
        brake_next = DSO_BRK_SLOW;
        state_next = DSO_ST_BRAKE;
      end
    end else begin
      unique case (state_reg)
        DSO_ST_IDLE: if (psm_resume_operation) blocked_next = 1'b0;
        DSO_ST_BRAKE: if (motor_standstill) begin
          brake_next = DSO_BRK_NONE;
          if (hold_after_reg) begin
            state_next = DSO_ST_HOLD;
            target_next = DSO_GO_QUICK_STOP;
          end else begin
            state_next = DSO_ST_IDLE;
          end
          goto_next = 1'b1;
        end
        DSO_ST_HOLD: if (psm_resume_operation) begin
          state_next = DSO_ST_IDLE;
          hold_after_next = 1'b0;
        end
        // Unused state code falls back to idle
        default: state_next = DSO_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= DSO_ST_IDLE;
      brake_reg <= DSO_BRK_NONE;
      target_reg <= DSO_GO_SWITCH_ON_DISABLED;
      hold_after_reg <= 1'b0;
      blocked_reg <= 1'b0;
      goto_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      brake_reg <= brake_next;
      target_reg <= target_next;
      hold_after_reg <= hold_after_next;
      blocked_reg <= blocked_next;
      goto_reg <= goto_next;
    end
  end

  assign brake_sel = brake_reg;
  assign drive_blocked = blocked_reg;
  assign hold_energized = (state_reg == DSO_ST_HOLD);
  assign goto_valid = goto_reg;
  assign goto_state = target_reg;

  // Checks
  sequence qs_seen(logic [15:0] c);
    psm_enter_quick_stop && qs_code_reg == c;
  endsequence

  sequence idle_stop;
    state_reg == DSO_ST_IDLE && !psm_enabled_to_ready && !psm_enabled_to_switched_on && !psm_resume_operation
    && !psm_enter_quick_stop;
  endsequence

  AST_DEN_NONZERO: assert property (@(posedge clk_sys) disable iff (!nrst) den_reg != 32'sh0000_0000)
    else $error("speed denominator became zero");
  AST_QS_RESERVED: assert property (@(posedge clk_sys) disable iff (!nrst)
    od_wr && od_index == DSO_IDX_QS_CODE && od_subindex == DSO_SUB_COUNT && od_wdata[15:0] == 16'h0003
    |=> qs_code_reg == $past(qs_code_reg) && od_err && od_ack)
    else $error("reserved quick stop code was not refused");
  AST_ENTRY_COUNT: assert property (@(posedge clk_sys) disable iff (!nrst)
    od_rd && !od_wr && od_index == DSO_IDX_VEL_SCALE && od_subindex == DSO_SUB_COUNT
    |=> od_rdata == DSO_ENTRY_COUNT && !od_err)
    else $error("entry count did not read two");
  AST_UNITY_DECEL: assert property (@(posedge clk_sys) disable iff (!nrst)
    (num_reg == den_reg && time_step_reg == 16'h0001 && spd_step_reg[31] == 1'b0)[*2]
    |-> qs_decel_rpm == $past(spd_step_reg))
    else $error("quick stop deceleration not speed over time");
  AST_SCALE_60: assert property (@(posedge clk_sys) disable iff (!nrst)
    (num_reg == 32'sd60 && den_reg == 32'sd1) ##1 (num_reg == 32'sd60 && den_reg == 32'sd1)
    |-> speed_rpm == 32'($past(speed_user) * 32'sd60))
    else $error("factor 60/1 not applied");
  AST_QS_IMMEDIATE: assert property (@(posedge clk_sys) disable iff (!nrst)
    qs_seen(DSO_CODE_0) |=> brake_sel == DSO_BRK_IMMEDIATE && goto_state == DSO_GO_SWITCH_ON_DISABLED)
    else $error("code 0 did not stop immediately");
  AST_QS_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst)
    qs_seen(DSO_CODE_6) ##1 (motor_standstill && !psm_enter_quick_stop && !psm_enabled_to_ready
    && !psm_enabled_to_switched_on) |=> hold_energized && goto_valid && goto_state == DSO_GO_QUICK_STOP)
    else $error("code 6 did not hold in quick stop");
  AST_SD_FREE: assert property (@(posedge clk_sys) disable iff (!nrst)
    psm_enabled_to_ready && !psm_enter_quick_stop && sd_code_reg == DSO_CODE_0
    |=> drive_blocked && goto_valid && goto_state == DSO_GO_READY && brake_sel == DSO_BRK_NONE)
    else $error("shutdown code 0 did not free the motor");
  AST_DIS_SLOW: assert property (@(posedge clk_sys) disable iff (!nrst)
    psm_enabled_to_switched_on && !psm_enabled_to_ready && !psm_enter_quick_stop && dis_code_reg == DSO_CODE_1
    |=> brake_sel == DSO_BRK_SLOW && !goto_valid)
    else $error("disable code 1 did not brake on slow ramp");
  AST_IDLE_QUIET: assert property (@(posedge clk_sys) disable iff (!nrst)
    idle_stop |=> !goto_valid)
    else $error("state request without an event");

endmodule // dso_stop_option

`default_nettype wire

// ===== logic/dso_pkg.sv
// Package: object indices, reset values, option codes and enums for the stop-option block
package dso_pkg;
  // Object indices and subindices
  localparam logic [15:0] DSO_IDX_QS_RAMP = 16'h604A;
  localparam logic [15:0] DSO_IDX_VEL_SCALE = 16'h604C;
  localparam logic [15:0] DSO_IDX_QS_CODE = 16'h605A;
  localparam logic [15:0] DSO_IDX_SD_CODE = 16'h605B;
  localparam logic [15:0] DSO_IDX_DIS_CODE = 16'h605C;
  localparam logic [7:0] DSO_SUB_COUNT = 8'h00;
  localparam logic [7:0] DSO_SUB_FIRST = 8'h01;
  localparam logic [7:0] DSO_SUB_SECOND = 8'h02;
  localparam logic [31:0] DSO_ENTRY_COUNT = 32'h0000_0002;
  // Values after reset
  localparam logic [31:0] DSO_RST_SPEED_STEP = 32'h0000_1388;
  localparam logic [15:0] DSO_RST_TIME_STEP = 16'h0001;
  localparam logic [31:0] DSO_RST_SCALE = 32'h0000_0001;
  localparam logic [15:0] DSO_RST_QS_CODE = 16'h0002;
  localparam logic [15:0] DSO_RST_SD_CODE = 16'h0001;
  localparam logic [15:0] DSO_RST_DIS_CODE = 16'h0001;
  // Option code values
  localparam logic [15:0] DSO_CODE_0 = 16'h0000;
  localparam logic [15:0] DSO_CODE_1 = 16'h0001;
  localparam logic [15:0] DSO_CODE_2 = 16'h0002;
  localparam logic [15:0] DSO_CODE_5 = 16'h0005;
  localparam logic [15:0] DSO_CODE_6 = 16'h0006;
  // Braking action driven to the motor control
  typedef enum logic [1:0] {DSO_BRK_NONE, DSO_BRK_IMMEDIATE, DSO_BRK_SLOW, DSO_BRK_QUICK} dso_brake_e;
  // Power state the block asks the state machine to enter
  typedef enum logic [1:0] {DSO_GO_SWITCH_ON_DISABLED, DSO_GO_READY, DSO_GO_SWITCHED_ON, DSO_GO_QUICK_STOP} dso_goto_e;
endpackage

// ===== test/dso_fb_ctrl.sv
// Fieldbus controller model issuing object reads and writes
`timescale 1ns/1ps
`default_nettype none
module dso_fb_ctrl (
  // Clock
  input wire logic clk_sys,
  // Object access port
  output logic od_wr,
  output logic od_rd,
  output logic [15:0] od_index,
  output logic [7:0] od_subindex,
  output logic [31:0] od_wdata,
  input wire logic [31:0] od_rdata,
  input wire logic od_ack,
  input wire logic od_err
);
  // Port idle until the first access
  initial begin
    od_wr = 1'b0;
    od_rd = 1'b0;
    od_index = 16'h0000;
    od_subindex = 8'h00;
    od_wdata = 32'h0000_0000;
  end
  // One-cycle request; answer taken while ack stands, lines then show stale-inverted values
  task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
                        output logic ack, output logic err, output logic [31:0] rd);
    @(posedge clk_sys);
    #1;
    od_wr = wr;
    od_rd = ~wr;
    od_index = idx;
    od_subindex = sub;
    od_wdata = wd;
    @(posedge clk_sys);
    #1;
    ack = od_ack;
    err = od_err;
    rd = od_rdata;
    od_wr = 1'b0;
    od_rd = 1'b0;
    od_index = ~idx;
    od_subindex = ~sub;
    od_wdata = ~wd;
  endtask
endmodule // dso_fb_ctrl
`default_nettype wire

// ===== test/tb_dso_stop_option.sv
// Testbench for the stop-option block: object access and stop sequences
`timescale 1ns/1ps
`default_nettype none
module tb_dso_stop_option;
  import dso_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic od_wr, od_rd, od_ack, od_err;
  logic [15:0] od_index;
  logic [7:0] od_subindex;
  logic [31:0] od_wdata, od_rdata;
  logic psm_enter_quick_stop = 1'b0, psm_enabled_to_ready = 1'b0;
  logic psm_enabled_to_switched_on = 1'b0, psm_resume_operation = 1'b0, motor_standstill = 1'b0;
  dso_brake_e brake_sel;
  dso_goto_e goto_state;
  logic drive_blocked, hold_energized, goto_valid;
  logic signed [31:0] speed_user = 32'sh0000_0064;
  logic signed [31:0] speed_rpm, qs_decel_rpm;
  int fails = 0;
  int tests_run = 0;
  // Reset-value table: index, subindex, expected read
  logic [15:0] ri [9] = '{16'h604A, 16'h604A, 16'h604A, 16'h604C, 16'h604C, 16'h604C, 16'h605A, 16'h605B, 16'h605C};
  logic [7:0] rs [9] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00};
  logic [31:0] rv [9] = '{32'h2, 32'h1388, 32'h1, 32'h2, 32'h1, 32'h1, 32'h2, 32'h1, 32'h1};
  // Quick-stop codes with expected brake, target and hold
  logic [15:0] qc [5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0005, 16'h0006};
  logic [1:0] qb [5] = '{DSO_BRK_IMMEDIATE, DSO_BRK_SLOW, DSO_BRK_QUICK, DSO_BRK_SLOW, DSO_BRK_QUICK};
  logic [1:0] qg [5] = '{DSO_GO_SWITCH_ON_DISABLED, DSO_GO_SWITCH_ON_DISABLED, DSO_GO_SWITCH_ON_DISABLED,
                         DSO_GO_QUICK_STOP, DSO_GO_QUICK_STOP};
  logic qh [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

  always #20 clk_sys = ~clk_sys;

  dso_fb_ctrl i_dso_fb_ctrl (.clk_sys(clk_sys), .od_wr(od_wr), .od_rd(od_rd), .od_index(od_index),
    .od_subindex(od_subindex), .od_wdata(od_wdata), .od_rdata(od_rdata), .od_ack(od_ack), .od_err(od_err));
  dso_stop_option i_dso_stop_option (.clk_sys(clk_sys), .nrst(nrst), .od_wr(od_wr), .od_rd(od_rd),
    .od_index(od_index), .od_subindex(od_subindex), .od_wdata(od_wdata), .od_rdata(od_rdata), .od_ack(od_ack),
    .od_err(od_err), .psm_enter_quick_stop(psm_enter_quick_stop), .psm_enabled_to_ready(psm_enabled_to_ready),
    .psm_enabled_to_switched_on(psm_enabled_to_switched_on), .psm_resume_operation(psm_resume_operation),
    .motor_standstill(motor_standstill), .brake_sel(brake_sel), .drive_blocked(drive_blocked),
    .hold_energized(hold_energized), .goto_valid(goto_valid), .goto_state(goto_state), .speed_user(speed_user),
    .speed_rpm(speed_rpm), .qs_decel_rpm(qs_decel_rpm));

  // Value comparison, counted
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Object write with expected refusal flag
  task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d, input logic e);
    logic a, g;
    logic [31:0] r;
    i_dso_fb_ctrl.access(1'b1, idx, sub, d, a, g, r);
    chk("od_ack", 32'h1, {31'h0, a});
    chk("od_err", {31'h0, e}, {31'h0, g});
  endtask
  // Object read with expected data and refusal flag
  task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] x, input logic e = 1'b0);
    logic a, g;
    logic [31:0] r;
    i_dso_fb_ctrl.access(1'b0, idx, sub, 32'h0, a, g, r);
    chk("od_ack", 32'h1, {31'h0, a});
    chk("od_err", {31'h0, e}, {31'h0, g});
    chk("od_rdata", x, r);
  endtask
  // Event pulse, braking, standstill, target request, then resume
  task automatic stop_run(input int ev, input logic [1:0] brk, input logic [1:0] go, input logic hold,
                          input logic blk);
    @(posedge clk_sys);
    #1;
    psm_enter_quick_stop = (ev == 0);
    psm_enabled_to_ready = (ev == 1);
    psm_enabled_to_switched_on = (ev == 2);
    @(posedge clk_sys);
    #1;
    psm_enter_quick_stop = 1'b0;
    psm_enabled_to_ready = 1'b0;
    psm_enabled_to_switched_on = 1'b0;
    chk("brake_sel", {30'h0, brk}, {30'h0, brake_sel});
    chk("drive_blocked", {31'h0, blk}, {31'h0, drive_blocked});
    // Coasting needs no standstill before the target request
    if (!blk) begin
      motor_standstill = 1'b1;
      @(posedge clk_sys);
      #1;
      motor_standstill = 1'b0;
    end
    chk("goto_valid", 32'h1, {31'h0, goto_valid});
    chk("goto_state", {30'h0, go}, {30'h0, goto_state});
    @(posedge clk_sys);
    #1;
    chk("goto_valid", 32'h0, {31'h0, goto_valid});
    chk("brake_sel", 32'h0, {30'h0, brake_sel});
    chk("hold_energized", {31'h0, hold}, {31'h0, hold_energized});
    psm_resume_operation = 1'b1;
    @(posedge clk_sys);
    #1;
    psm_resume_operation = 1'b0;
    chk("hold_energized", 32'h0, {31'h0, hold_energized});
    chk("drive_blocked", 32'h0, {31'h0, drive_blocked});
  endtask
  // Verdict and end of run
  task automatic conclude();
    if (fails == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs well under 1000 cycles
  initial begin
    #(40 * 3000);
    fails++;
    conclude();
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    for (int i = 0; i < 9; i++) rd(ri[i], rs[i], rv[i]);
    wr(16'h604C, 8'h00, 32'h5, 1'b1);
    wr(16'h604C, 8'h02, 32'h0, 1'b1);
    rd(16'h604C, 8'h02, 32'h1);
    wr(16'h605A, 8'h00, 32'h3, 1'b1);
    wr(16'h605B, 8'h00, 32'h2, 1'b1);
    rd(16'h605A, 8'h00, 32'h2);
    rd(16'h605B, 8'h00, 32'h1);
    rd(16'h6000, 8'h00, 32'h0, 1'b1);
    // Numerator 60 over 1: user speed in revolutions per second
    wr(16'h604C, 8'h01, 32'd60, 1'b0);
    @(posedge clk_sys);
    #1;
    chk("speed_rpm", 32'd6000, speed_rpm);
    chk("qs_decel_rpm", 32'd300000, qs_decel_rpm);
    // Fractional factor with a negative speed and a longer time step
    wr(16'h604C, 8'h01, 32'd3, 1'b0);
    wr(16'h604C, 8'h02, 32'd2, 1'b0);
    wr(16'h604A, 8'h02, 32'd4, 1'b0);
    speed_user = -32'sd10;
    @(posedge clk_sys);
    #1;
    chk("speed_rpm", 32'hFFFF_FFF1, speed_rpm);
    chk("qs_decel_rpm", 32'd1875, qs_decel_rpm);
    for (int i = 0; i < 5; i++) begin
      wr(16'h605A, 8'h00, {16'h0, qc[i]}, 1'b0);
      stop_run(0, qb[i], qg[i], qh[i], 1'b0);
    end
    wr(16'h605B, 8'h00, 32'h0, 1'b0);
    stop_run(1, DSO_BRK_NONE, DSO_GO_READY, 1'b0, 1'b1);
    wr(16'h605B, 8'h00, 32'h1, 1'b0);
    stop_run(1, DSO_BRK_SLOW, DSO_GO_READY, 1'b0, 1'b0);
    wr(16'h605C, 8'h00, 32'h0, 1'b0);
    stop_run(2, DSO_BRK_NONE, DSO_GO_SWITCHED_ON, 1'b0, 1'b1);
    wr(16'h605C, 8'h00, 32'h1, 1'b0);
    stop_run(2, DSO_BRK_SLOW, DSO_GO_SWITCHED_ON, 1'b0, 1'b0);
    conclude();
  end
endmodule // tb_dso_stop_option
`default_nettype wire
